// ### src/bbt_core.sv
// Execution core for branch, bit, shift, flag and data transfer operations.
// Function
// - Greater-or-equal branch jumps by offset plus one when N xor V is 0.
// - Signed less-than branch jumps by offset plus one when N xor V is 1.
// - Half-carry branches jump on H one or zero, flags untouched.
// - T-flag branches jump on T one or zero to PC plus offset plus one.
// - Overflow branches jump on V set or clear, flags untouched.
// - Interrupt-enable branches jump on I set or clear.
// - I/O bit set and clear force one I/O bit in two cycles.
// - Left shift inserts zero, left rotate inserts carry; Z,C,N,V updated.
// - Right shift inserts zero, right rotate inserts carry; Z,C,N,V set.
// - Bit store copies a register bit into T in one cycle.
// - Bit load writes T into a register bit, flags untouched.
// - One-cycle instructions set or clear any single status flag.
// - Clear-overflow writes V to zero, other flags untouched.
// - Post-increment load reads at pointer, then adds one, two cycles.
// - Pre-decrement load subtracts one first, then reads, two cycles.
// - Displacement load reads at Y or Z plus displacement, pointer kept.
// - Post-increment store writes at pointer, then adds one, two cycles.
// - Pre-decrement store subtracts one first, then writes, two cycles.
// - Displacement store writes at Y or Z plus displacement, pointer kept.
// - Direct load reads the address in the instruction, two cycles.
// - Direct store writes to the address in the instruction, two cycles.
//
// The address-and-strobe port and the register addresses were decided locally.
`default_nettype none
module bbt_core
  import bbt_pkg::*;
(
  input wire logic ref_clk_i,
  input wire logic srst_i,
  input wire logic instr_valid_i,
  input wire bbt_instr_s instr_i,
  output logic instr_ready_o,
  output bbt_dmem_s dmem_o,
  input wire logic [7:0] dmem_rdata_i,
  output bbt_io_s io_o,
  output logic [15:0] pc_o,
  output logic [7:0] flags_o,
  input wire logic [5:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic reg_we_i,
  input wire logic reg_re_i,
  output logic [7:0] reg_rdata_o
);
  logic [7:0] rf [RF_DEPTH];
  bbt_state_e state;
  logic [4:0] load_rd;
  logic load_pend;
  logic accept;
  logic [4:0] ptr_lo;
  logic [4:0] ptr_hi;
  logic [15:0] ptr_val;
  logic [15:0] ea;
  logic [15:0] next_ptr;
  logic [15:0] k_ext;
  logic [15:0] next_pc;
  logic taken;
  logic is_shift;
  logic [7:0] src;
  logic [7:0] sh_res;
  logic sh_c;
  logic [7:0] next_flags;

  assign accept = instr_valid_i && instr_ready_o;
  assign ptr_lo = (instr_i.ptr == ptr_x) ? PTR_X_LO :
                  (instr_i.ptr == ptr_y) ? PTR_Y_LO : PTR_Z_LO;
  assign ptr_hi = ptr_lo + 5'h01;
  assign ptr_val = {rf[ptr_hi], rf[ptr_lo]};
  assign k_ext = {{9{instr_i.k[6]}}, instr_i.k};
  assign src = rf[instr_i.rd];

  // Effective address and pointer write-back.
  always_comb begin
    next_ptr = ptr_val;
    ea = ptr_val;
    case (instr_i.mode)
      am_direct: ea = instr_i.addr;
      am_post_inc: next_ptr = ptr_val + PC_STEP;
      am_pre_dec: begin
        next_ptr = ptr_val - PC_STEP;
        ea = next_ptr;
      end
      am_disp: ea = ptr_val + {10'h000, instr_i.disp};
      default: ea = ptr_val;
    endcase
  end

  // Branch condition.
  always_comb begin
    case (instr_i.op)
      branch_flag_one: taken = flags_o[instr_i.sel];
      branch_flag_zero: begin
        taken = !flags_o[instr_i.sel];
      end
      branch_signed_ge: taken = !(flags_o[FLAG_N] ^ flags_o[FLAG_V]);
      branch_signed_lt: taken = flags_o[FLAG_N] ^ flags_o[FLAG_V];
      default: taken = 1'b0;
    endcase
  end

  // Shift and rotate unit.
  always_comb begin
    is_shift = 1'b1;
    sh_c = src[0];
    sh_res = src;
    case (instr_i.op)
      shift_left_logical: begin
        sh_res = {src[6:0], 1'b0};
        sh_c = src[7];
      end
      rotate_left_carry: begin
        sh_res = {src[6:0], flags_o[FLAG_C]};
        sh_c = src[7];
      end
      shift_right_logical: sh_res = {1'b0, src[7:1]};
      rotate_right_carry: sh_res = {flags_o[FLAG_C], src[7:1]};
      shift_right_arith: sh_res = {src[7], src[7:1]};
      default: is_shift = 1'b0;
    endcase
  end

  // Status flag next value.
  always_comb begin
    next_flags = flags_o;
    if (accept) begin
      if (is_shift) begin
        next_flags[FLAG_Z] = (sh_res == BYTE_ZERO);
        next_flags[FLAG_C] = sh_c;
        next_flags[FLAG_N] = sh_res[7];
        next_flags[FLAG_V] = sh_res[7] ^ sh_c;
      end else if (instr_i.op == bit_to_transfer_flag) begin
        next_flags[FLAG_T] = src[instr_i.sel];
      end else if (instr_i.op == flag_set) begin
        next_flags[instr_i.sel] = 1'b1;
      end else if (instr_i.op == flag_clear) begin
        next_flags[instr_i.sel] = 1'b0;
      end
    end
  end

  always_comb begin
    next_pc = pc_o + PC_STEP;
    if (taken) begin
      next_pc = pc_o + k_ext + PC_STEP;
    end else if (instr_i.op == mem_access && instr_i.mode == am_direct) begin
      next_pc = pc_o + PC_STEP_LONG;
    end
  end

  // Sequencer: two-cycle work holds the instruction port for one cycle.
  always_ff @(posedge ref_clk_i) begin
    if (srst_i) begin
      state <= seq_run;
      instr_ready_o <= 1'b1;
      pc_o <= PC_RST;
    end else begin
      case (state)
        seq_run: begin
          if (accept) begin
            pc_o <= next_pc;
            if (taken || instr_i.op == mem_access ||
                instr_i.op == io_bit_set || instr_i.op == io_bit_clear) begin
              state <= seq_second;
              instr_ready_o <= 1'b0;
            end
          end
        end
        seq_second: begin
          state <= seq_run;
          instr_ready_o <= 1'b1;
        end
        default: begin
          state <= seq_run;
          instr_ready_o <= 1'b1;
        end
      endcase
    end
  end

  // An accepted instruction is checked first, so it wins and a same-cycle software write is dropped.
  always_ff @(posedge ref_clk_i) begin
    if (srst_i) begin
      flags_o <= FLAGS_RST;
    end else if (accept) begin
      flags_o <= next_flags;
    end else if (reg_we_i && reg_addr_i == REG_FLAGS) begin
      flags_o <= reg_wdata_i;
    end
  end

  // Working register file.
  always_ff @(posedge ref_clk_i) begin
    if (reg_we_i && reg_addr_i < REG_FLAGS) begin
      rf[reg_addr_i[4:0]] <= reg_wdata_i;
    end
    if (load_pend) begin
      rf[load_rd] <= dmem_rdata_i;
    end
    if (accept) begin
      if (is_shift) begin
        rf[instr_i.rd] <= sh_res;
      end else if (instr_i.op == transfer_flag_to_bit) begin
        rf[instr_i.rd][instr_i.sel] <= flags_o[FLAG_T];
      end else if (instr_i.op == mem_access &&
                   (instr_i.mode == am_post_inc ||
                    instr_i.mode == am_pre_dec)) begin
        rf[ptr_lo] <= next_ptr[7:0];
        rf[ptr_hi] <= next_ptr[15:8];
      end
    end
  end

  // Data memory strobes stand for the second cycle only.
  always_ff @(posedge ref_clk_i) begin
    if (srst_i) begin
      dmem_o <= '0;
      load_pend <= 1'b0;
      load_rd <= 5'h00;
    end else begin
      dmem_o.re <= 1'b0;
      dmem_o.we <= 1'b0;
      load_pend <= 1'b0;
      if (accept && instr_i.op == mem_access) begin
        dmem_o.addr <= ea;
        dmem_o.wdata <= src;
        dmem_o.re <= !instr_i.store;
        dmem_o.we <= instr_i.store;
        load_pend <= !instr_i.store;
        load_rd <= instr_i.rd;
      end
    end
  end

  // The I/O space performs the bit update itself on the pulse.
  always_ff @(posedge ref_clk_i) begin
    if (srst_i) begin
      io_o <= '0;
    end else begin
      io_o.set <= accept && instr_i.op == io_bit_set;
      io_o.clr <= accept && instr_i.op == io_bit_clear;
      if (accept) begin
        io_o.addr <= instr_i.io;
        io_o.bitsel <= instr_i.sel;
      end
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (srst_i) begin
      reg_rdata_o <= BYTE_ZERO;
    end else if (reg_re_i) begin
      if (reg_addr_i < REG_FLAGS) begin
        reg_rdata_o <= rf[reg_addr_i[4:0]];
      end else if (reg_addr_i == REG_FLAGS) begin
        reg_rdata_o <= flags_o;
      end else if (reg_addr_i == REG_PC_LO) begin
        reg_rdata_o <= pc_o[7:0];
      end else if (reg_addr_i == REG_PC_HI) begin
        reg_rdata_o <= pc_o[15:8];
      end else begin
        reg_rdata_o <= BYTE_ZERO;
      end
    end
  end

  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (srst_i);

  branch_ge_a: assert property (
    accept && instr_i.op == branch_signed_ge &&
    !(flags_o[FLAG_N] ^ flags_o[FLAG_V])
    |=> pc_o == $past(pc_o) + $past(k_ext) + PC_STEP && !instr_ready_o)
    else $error("signed ge branch not taken");
  branch_lt_a: assert property (
    accept && instr_i.op == branch_signed_lt &&
    (flags_o[FLAG_N] ^ flags_o[FLAG_V])
    |=> pc_o == $past(pc_o) + $past(k_ext) + PC_STEP &&
        flags_o == $past(flags_o))
    else $error("signed lt branch wrong");
  flag_branch_a: assert property (
    accept && (instr_i.op == branch_flag_one ||
               instr_i.op == branch_flag_zero)
    |=> flags_o == $past(flags_o) &&
        (pc_o == $past(pc_o) + PC_STEP) == !$past(taken))
    else $error("flag branch wrong");
  branch_time_a: assert property (
    accept && instr_i.op inside {branch_flag_one, branch_flag_zero,
      branch_signed_ge, branch_signed_lt}
    |=> (instr_ready_o != $past(taken)) ##1 instr_ready_o)
    else $error("branch cycle count wrong");
  io_bit_a: assert property (
    accept && instr_i.op == io_bit_set
    |=> io_o.set && !io_o.clr && io_o.addr == $past(instr_i.io) &&
        flags_o == $past(flags_o) ##1 !io_o.set && instr_ready_o)
    else $error("io bit set wrong");
  shift_left_a: assert property (
    accept && instr_i.op == shift_left_logical
    |=> rf[$past(instr_i.rd)] == {$past(src[6:0]), 1'b0} &&
        flags_o[FLAG_C] == $past(src[7]) && instr_ready_o)
    else $error("left shift wrong");
  shift_arith_a: assert property (
    accept && instr_i.op == shift_right_arith
    |=> rf[$past(instr_i.rd)][7] == $past(src[7]) &&
        flags_o[FLAG_C] == $past(src[0]))
    else $error("arithmetic shift wrong");
  bit_store_a: assert property (
    accept && instr_i.op == bit_to_transfer_flag
    |=> flags_o[FLAG_T] == $past(src[instr_i.sel]) &&
        flags_o[5:0] == $past(flags_o[5:0]))
    else $error("bit store wrong");
  clear_v_a: assert property (
    accept && instr_i.op == flag_clear && instr_i.sel == FLAG_V
    |=> !flags_o[FLAG_V] && flags_o[2:0] == $past(flags_o[2:0]))
    else $error("overflow clear wrong");
  post_inc_a: assert property (
    accept && instr_i.op == mem_access && !instr_i.store &&
    instr_i.mode == am_post_inc
    |=> dmem_o.re && dmem_o.addr == $past(ptr_val) ##1
        !dmem_o.re && instr_ready_o)
    else $error("post increment load wrong");
  pre_dec_store_a: assert property (
    accept && instr_i.op == mem_access && instr_i.store &&
    instr_i.mode == am_pre_dec
    |=> dmem_o.we && dmem_o.addr == $past(ptr_val) - PC_STEP &&
        dmem_o.wdata == $past(src))
    else $error("pre decrement store wrong");
  rotate_right_a: assert property (
    accept && instr_i.op == rotate_right_carry
    |=> rf[$past(instr_i.rd)] ==
        {$past(flags_o[FLAG_C]), $past(src[7:1])} &&
        flags_o[FLAG_C] == $past(src[0]) &&
        flags_o[FLAG_V] == (flags_o[FLAG_N] ^ flags_o[FLAG_C]))
    else $error("right rotate wrong");
  bit_load_a: assert property (
    accept && instr_i.op == transfer_flag_to_bit
    |=> rf[$past(instr_i.rd)][$past(instr_i.sel)] == flags_o[FLAG_T] &&
        flags_o == $past(flags_o))
    else $error("bit load wrong");
  flag_set_a: assert property (
    accept && instr_i.op == flag_set
    |=> flags_o == ($past(flags_o) | (8'h01 << $past(instr_i.sel))))
    else $error("flag set wrong");
  flag_clr_a: assert property (
    accept && instr_i.op == flag_clear
    |=> flags_o == ($past(flags_o) & ~(8'h01 << $past(instr_i.sel))))
    else $error("flag clear wrong");
  pre_dec_load_a: assert property (
    accept && instr_i.op == mem_access && !instr_i.store &&
    instr_i.mode == am_pre_dec
    |=> dmem_o.re && dmem_o.addr == $past(ptr_val) - PC_STEP &&
        {rf[$past(ptr_hi)], rf[$past(ptr_lo)]} == dmem_o.addr)
    else $error("pre decrement load wrong");
  disp_mem_a: assert property (
    accept && instr_i.op == mem_access && instr_i.mode == am_disp
    |=> dmem_o.addr == $past(ptr_val) + {10'h000, $past(instr_i.disp)} &&
        dmem_o.we == $past(instr_i.store))
    else $error("displacement access wrong");
  post_inc_store_a: assert property (
    accept && instr_i.op == mem_access && instr_i.store &&
    instr_i.mode == am_post_inc
    |=> dmem_o.we && dmem_o.addr == $past(ptr_val) &&
        {rf[$past(ptr_hi)], rf[$past(ptr_lo)]} == $past(ptr_val) + PC_STEP)
    else $error("post increment store wrong");
  direct_mem_a: assert property (
    accept && instr_i.op == mem_access && instr_i.mode == am_direct
    |=> dmem_o.addr == $past(instr_i.addr) &&
        pc_o == $past(pc_o) + PC_STEP_LONG && flags_o == $past(flags_o) &&
        !instr_ready_o ##1 instr_ready_o)
    else $error("direct access wrong");
  load_data_a: assert property (
    load_pend |=> rf[$past(load_rd)] == $past(dmem_rdata_i))
    else $error("load data not written");

  taken_cov: cover property (accept && taken);
  load_cov: cover property (accept && instr_i.op == mem_access &&
    !instr_i.store ##2 accept);
  io_cov: cover property (io_o.clr);
  store_cov: cover property (dmem_o.we);
  shift_cov: cover property (accept && is_shift);
endmodule // bbt_core
`default_nettype wire

// ### src/bbt_pkg.sv
// Package with constants, enumerations and carriers of the execution core.
`default_nettype none
package bbt_pkg;
  localparam int PC_W = 16;
  localparam int DATA_W = 8;
  localparam int RF_DEPTH = 32;
  localparam int REG_ADDR_W = 6;
  localparam logic [2:0] FLAG_C = 3'h0;
  localparam logic [2:0] FLAG_Z = 3'h1;
  localparam logic [2:0] FLAG_N = 3'h2;
  localparam logic [2:0] FLAG_V = 3'h3;
  localparam logic [2:0] FLAG_S = 3'h4;
  localparam logic [2:0] FLAG_H = 3'h5;
  localparam logic [2:0] FLAG_T = 3'h6;
  localparam logic [2:0] FLAG_I = 3'h7;
  localparam logic [4:0] PTR_X_LO = 5'h1A;
  localparam logic [4:0] PTR_Y_LO = 5'h1C;
  localparam logic [4:0] PTR_Z_LO = 5'h1E;
  localparam logic [5:0] REG_FLAGS = 6'h20;
  localparam logic [5:0] REG_PC_LO = 6'h21;
  localparam logic [5:0] REG_PC_HI = 6'h22;
  localparam logic [7:0] FLAGS_RST = 8'h00;
  localparam logic [15:0] PC_RST = 16'h0000;
  localparam logic [15:0] PC_STEP = 16'h0001;
  localparam logic [15:0] PC_STEP_LONG = 16'h0002;
  localparam logic [7:0] BYTE_ZERO = 8'h00;

  typedef enum logic [3:0] {
    branch_flag_one = 4'h0, branch_flag_zero = 4'h1,
    branch_signed_ge = 4'h2, branch_signed_lt = 4'h3,
    io_bit_set = 4'h4, io_bit_clear = 4'h5,
    shift_left_logical = 4'h6, shift_right_logical = 4'h7,
    rotate_left_carry = 4'h8, rotate_right_carry = 4'h9,
    shift_right_arith = 4'hA, bit_to_transfer_flag = 4'hB,
    transfer_flag_to_bit = 4'hC, flag_set = 4'hD, flag_clear = 4'hE,
    mem_access = 4'hF
  } bbt_op_e;

  typedef enum logic [2:0] {
    am_direct = 3'h0, am_plain = 3'h1, am_post_inc = 3'h2,
    am_pre_dec = 3'h3, am_disp = 3'h4
  } bbt_mode_e;

  typedef enum logic [1:0] {
    ptr_x = 2'h0, ptr_y = 2'h1, ptr_z = 2'h2
  } bbt_ptr_e;

  typedef enum logic [1:0] {
    seq_run = 2'h1, seq_second = 2'h2
  } bbt_state_e;

  typedef struct packed {
    bbt_op_e op;
    logic store;
    bbt_mode_e mode;
    bbt_ptr_e ptr;
    logic [4:0] rd;
    logic [2:0] sel;
    logic [6:0] k;
    logic [5:0] disp;
    logic [15:0] addr;
    logic [4:0] io;
  } bbt_instr_s;

  typedef struct packed {
    logic [15:0] addr;
    logic [7:0] wdata;
    logic re;
    logic we;
  } bbt_dmem_s;

  typedef struct packed {
    logic [4:0] addr;
    logic [2:0] bitsel;
    logic set;
    logic clr;
  } bbt_io_s;
endpackage
`default_nettype wire

// ### testbench/bbt_dmem_model.sv
// Data memory and I/O register space model facing the core.
`default_nettype none
module bbt_dmem_model
  import bbt_pkg::*;
(
  input wire logic ref_clk_i,
  input wire bbt_dmem_s dmem_i,
  output logic [7:0] rdata_o,
  input wire bbt_io_s io_i
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] mem [0:65535];
  logic [7:0] io_space [0:31];
  logic [7:0] last = 8'h00;
  initial begin
    for (int i = 0; i < 65536; i++) mem[i] = i[7:0] ^ 8'h5A;
    for (int i = 0; i < 32; i++) io_space[i] = 8'h00;
  end
  // Outside a read the bus toggles, so a core sampling late cannot pass.
  assign rdata_o = dmem_i.re ? mem[dmem_i.addr] : ~last;
  always @(posedge ref_clk_i) begin
    last <= rdata_o;
    if (dmem_i.we) mem[dmem_i.addr] <= dmem_i.wdata;
    if (io_i.set) io_space[io_i.addr][io_i.bitsel] <= 1'b1;
    if (io_i.clr) io_space[io_i.addr][io_i.bitsel] <= 1'b0;
  end
endmodule // bbt_dmem_model
`default_nettype wire

// ### testbench/tb_cpu_branch_bit_transfer_ops.sv
// Self-checking bench for the branch, bit, shift and transfer core.
`default_nettype none
module tb_cpu_branch_bit_transfer_ops
  import bbt_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0;
  logic srst = 1'b1;
  logic iv = 1'b0;
  bbt_instr_s ins = '0;
  logic rdy;
  bbt_dmem_s dm;
  logic [7:0] rdat;
  bbt_io_s io;
  logic [15:0] pc;
  logic [7:0] fl;
  logic [5:0] ra = 6'h00;
  logic [7:0] rwd = 8'h00;
  logic rwe = 1'b0;
  logic rre = 1'b0;
  logic [7:0] rrd;
  int n_mismatch = 0;
  int total_checks = 0;
  int cyc = 0;
  logic [15:0] epc;
  logic [7:0] ef;
  logic rdy1;
  bbt_dmem_s dm1;
  bbt_io_s io1;
  logic [7:0] v;
  logic [15:0] w;
  logic [2:0] bsel [4] = '{FLAG_H, FLAG_T, FLAG_V, FLAG_I};
  bbt_op_e sh [5] = '{shift_left_logical, shift_right_logical,
    rotate_left_carry, rotate_right_carry, shift_right_arith};
  logic [7:0] sv [3] = '{8'h81, 8'h80, 8'h01};

  always #5 clk = ~clk;

  bbt_core u_bbt_core (.ref_clk_i(clk), .srst_i(srst), .instr_valid_i(iv),
    .instr_i(ins), .instr_ready_o(rdy), .dmem_o(dm), .dmem_rdata_i(rdat),
    .io_o(io), .pc_o(pc), .flags_o(fl), .reg_addr_i(ra), .reg_wdata_i(rwd),
    .reg_we_i(rwe), .reg_re_i(rre), .reg_rdata_o(rrd));
  bbt_dmem_model u_bbt_dmem_model (.ref_clk_i(clk), .dmem_i(dm),
    .rdata_o(rdat), .io_i(io));

  task automatic chk(string nm, logic [15:0] seen, logic [15:0] exp);
    total_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic end_sim();
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  // The run is a few hundred cycles; this ceiling only cuts a hang.
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_mismatch++;
      end_sim();
    end
  end

  task automatic reg_wr(logic [5:0] a, logic [7:0] d);
    @(posedge clk);
    ra <= a;
    rwd <= d;
    rwe <= 1'b1;
    @(posedge clk);
    rwe <= 1'b0;
    #1;
  endtask

  task automatic reg_rd(logic [5:0] a, output logic [7:0] d);
    @(posedge clk);
    ra <= a;
    rre <= 1'b1;
    @(posedge clk);
    rre <= 1'b0;
    #1;
    d = rrd;
  endtask

  function automatic bbt_instr_s mk(bbt_op_e op, logic [4:0] rd,
      logic [2:0] sel, logic [6:0] k);
    mk = '0;
    mk.op = op;
    mk.rd = rd;
    mk.io = rd;
    mk.sel = sel;
    mk.k = k;
  endfunction

  function automatic bbt_instr_s mm(logic s, bbt_mode_e md, bbt_ptr_e p,
      logic [5:0] q, logic [15:0] a);
    mm = mk(mem_access, s ? 5'h09 : 5'h02, 3'h0, 7'h00);
    mm.store = s;
    mm.mode = md;
    mm.ptr = p;
    mm.disp = q;
    mm.addr = a;
  endfunction

  // Offers one instruction, holds it until taken, snapshots cycle + 1.
  task automatic exec(bbt_instr_s x, logic [15:0] step);
    @(posedge clk);
    iv <= 1'b1;
    ins <= x;
    #1;
    while (rdy !== 1'b1) begin
      @(posedge clk);
      #1;
    end
    @(posedge clk);
    iv <= 1'b0;
    #1;
    rdy1 = rdy;
    dm1 = dm;
    io1 = io;
    epc = epc + step;
  endtask

  task automatic setf(logic [2:0] i, logic b);
    exec(mk(b ? flag_set : flag_clear, 5'h00, i, 7'h00), PC_STEP);
    ef[i] = b;
    chk("flags", fl, ef);
    chk("ready", rdy1, 1'b1);
  endtask

  task automatic br(bbt_op_e op, logic [2:0] s, logic tk, logic [6:0] k);
    exec(mk(op, 5'h00, s, k), tk ? {{9{k[6]}}, k} + PC_STEP : PC_STEP);
    chk("pc", pc, epc);
    chk("ready", rdy1, !tk);
    chk("flags", fl, ef);
  endtask

  task automatic exp_shift(bbt_op_e op, logic [7:0] a);
    logic c;
    case (op)
      shift_left_logical: {c, w[7:0]} = {a, 1'b0};
      rotate_left_carry: {c, w[7:0]} = {a, ef[FLAG_C]};
      shift_right_logical: {w[7:0], c} = {1'b0, a};
      rotate_right_carry: {w[7:0], c} = {ef[FLAG_C], a};
      default: {w[7:0], c} = {a[7], a};
    endcase
    ef[FLAG_C] = c;
    ef[FLAG_Z] = (w[7:0] == 8'h00);
    ef[FLAG_N] = w[7];
    ef[FLAG_V] = w[7] ^ c;
  endtask

  task automatic mop(logic s, bbt_mode_e md, bbt_ptr_e p, logic [5:0] q,
      logic [15:0] a, logic [15:0] ea, logic [15:0] ep);
    logic [5:0] lo;
    logic [7:0] h;
    lo = {1'b0, PTR_X_LO + {2'b00, p, 1'b0}};
    exec(mm(s, md, p, q, a), md == am_direct ? PC_STEP_LONG : PC_STEP);
    chk("addr", dm1.addr, ea);
    chk("strobe", {dm1.re, dm1.we}, {!s, s});
    chk("ready", rdy1, 1'b0);
    chk("pc", pc, epc);
    chk("flags", fl, ef);
    reg_rd(lo, v);
    reg_rd(lo + 6'h01, h);
    chk("pointer", {h, v}, ep);
    reg_rd(s ? 6'h09 : 6'h02, v);
    chk("data", s ? u_bbt_dmem_model.mem[ea] : v,
      s ? 8'hC3 : ea[7:0] ^ 8'h5A);
  endtask

  initial begin
    epc = PC_RST;
    ef = FLAGS_RST;
    repeat (16) @(posedge clk);
    srst <= 1'b0;
    #1;
    chk("pc reset", pc, PC_RST);
    chk("flags reset", fl, FLAGS_RST);
    for (int i = 0; i < 8; i++) setf(i[2:0], 1'b1);
    for (int i = 0; i < 8; i++) setf(i[2:0], 1'b0);
    reg_rd(REG_FLAGS, v);
    chk("flags reg", v, ef);
    reg_wr(6'h30, 8'hFF);
    reg_rd(6'h30, v);
    chk("unmapped", v, 8'h00);
    foreach (bsel[j]) for (int b = 0; b < 2; b++) begin
      setf(bsel[j], b[0]);
      br(branch_flag_one, bsel[j], b[0], 7'h05);
      br(branch_flag_zero, bsel[j], !b[0], 7'h7C);
    end
    for (int m = 0; m < 4; m++) begin
      setf(FLAG_N, m[0]);
      setf(FLAG_V, m[1]);
      br(branch_signed_ge, 3'h0, !(m[0] ^ m[1]), 7'h3F);
      br(branch_signed_lt, 3'h0, m[0] ^ m[1], 7'h40);
    end
    foreach (sh[j]) for (int m = 0; m < 3; m++) begin
      reg_wr(6'h10, sv[m]);
      setf(FLAG_C, m == 0);
      exec(mk(sh[j], 5'h10, 3'h0, 7'h00), PC_STEP);
      exp_shift(sh[j], sv[m]);
      reg_rd(6'h10, v);
      chk("shift", v, w[7:0]);
      chk("flags", fl, ef);
      chk("ready", rdy1, 1'b1);
    end
    reg_wr(6'h05, 8'hB4);
    reg_wr(6'h06, 8'h00);
    for (int b = 0; b < 8; b++) begin
      exec(mk(bit_to_transfer_flag, 5'h05, b[2:0], 7'h00), PC_STEP);
      w[7:0] = 8'hB4;
      ef[FLAG_T] = w[b];
      chk("flags", fl, ef);
      exec(mk(transfer_flag_to_bit, 5'h06, 3'(7 - b), 7'h00), PC_STEP);
      chk("flags", fl, ef);
      chk("ready", rdy1, 1'b1);
    end
    reg_rd(6'h06, v);
    chk("bit load", v, 8'h2D);
    for (int b = 0; b < 2; b++) begin
      exec(mk(b ? io_bit_clear : io_bit_set, 5'h0C, 3'h3, 7'h00), PC_STEP);
      chk("io", {io1.set, io1.clr, io1.addr, io1.bitsel},
        {!b[0], b[0], 5'h0C, 3'h3});
      chk("ready", rdy1, 1'b0);
      chk("flags", fl, ef);
      @(posedge clk);
      #1;
      chk("io bit", u_bbt_dmem_model.io_space[12],
        b ? 8'h00 : 8'h08);
    end
    reg_wr(6'h09, 8'hC3);
    reg_wr(6'h1B, 8'h01);
    reg_wr(6'h1A, 8'h00);
    reg_wr(6'h1D, 8'h02);
    reg_wr(6'h1C, 8'h00);
    reg_wr(6'h1F, 8'h03);
    reg_wr(6'h1E, 8'h00);
    mop(1'b0, am_post_inc, ptr_x, 6'h00, 16'h0, 16'h0100, 16'h0101);
    mop(1'b0, am_pre_dec, ptr_x, 6'h00, 16'h0, 16'h0100, 16'h0100);
    mop(1'b1, am_pre_dec, ptr_x, 6'h00, 16'h0, 16'h00FF, 16'h00FF);
    mop(1'b1, am_post_inc, ptr_x, 6'h00, 16'h0, 16'h00FF, 16'h0100);
    mop(1'b0, am_disp, ptr_y, 6'h3F, 16'h0, 16'h023F, 16'h0200);
    mop(1'b1, am_disp, ptr_z, 6'h01, 16'h0, 16'h0301, 16'h0300);
    mop(1'b0, am_plain, ptr_z, 6'h00, 16'h0, 16'h0300, 16'h0300);
    mop(1'b0, am_direct, ptr_x, 6'h00, 16'h1234, 16'h1234, 16'h0100);
    mop(1'b1, am_direct, ptr_x, 6'h00, 16'h0456, 16'h0456, 16'h0100);
    reg_wr(REG_PC_LO, 8'hFF);
    reg_rd(REG_PC_LO, v);
    chk("pc low", v, epc[7:0]);
    reg_rd(REG_PC_HI, v);
    chk("pc high", v, epc[15:8]);
    end_sim();
  end
endmodule // tb_cpu_branch_bit_transfer_ops
`default_nettype wire
